// File: rav_angle_if.sv
// Summary of operation
// - each counter update comes with a positive strobe of 0.4 to 0.7 us.
// - counter data changes 50 ns after strobe rise, valid by 0.2 us.
// - angle is the sum of weights of set bits, msb weighs most.
// - hold request low freezes the output latch within 0.3 us.
// - latch passes data while strobe low, locks while strobe high.
// - hold during strobe locks after strobe; strobe during hold changes nothing.
// - hold never stops the internal counter from tracking.
// - 8-bit host reads upper then lower byte; 16-bit host reads both at once.
// - upper enable drives the 8 msbs, lower enable the remaining bits.
// - select code 00/01/10/11 gives 10/12/14/16 bits, changeable while running.
// - resolution select is latched on the strobe trailing edge.
// - output bits beyond the selected resolution read zero.
// - wrap flag low at all ones counting up or all zeros counting down.
// - direction 1 up, 0 down; valid 0.5 us before to 20 ns after strobe.
// - tracking flag drops above 65 lsb error, over-velocity or loop fault.
// - loss flag rises when both resolver inputs are disconnected.
// - loop speed select 0 gives low bandwidth, 1 high, changeable live.
// - mode pin low enters compare mode with double-buffered angle input.
// - in compare mode each load or transfer latch is open while its control is 1.
// - low byte carries bits 9 to 10, 12, 14 or 16 per resolution.
// - angle drivers release within 100 ns after both enables return high.
`timescale 1ns/1ps
`default_nettype none
`include "rav_regs.svh"
module rav_angle_if (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic vco_step,
  input wire logic vco_up,
  input wire logic [7:0] loop_err_lsb,
  input wire logic over_velocity,
  input wire logic loop_fault,
  input wire logic sin_lost,
  input wire logic cos_lost,
  input wire logic freeze_n,
  input wire logic upper_byte_out_en_n,
  input wire logic lower_byte_out_en_n,
  input wire logic angle_compare_mode_n,
  input wire logic [15:0] angle_in,
  output logic [15:0] angle_out,
  output logic [1:0] angle_oe,
  output logic update_strobe,
  output logic direction,
  output logic wrap_flag_n,
  output logic track_ok,
  output logic signal_missing,
  output logic loop_speed_sel,
  output rav_pkg::rav_angle_type ct_angle
);
  import rav_pkg::*;

  // cycle counts are the timing figures rounded up to whole clocks
  localparam int LEAD_CYC = `RAV_DIR_SETUP_CYC;
  localparam int HIGH_CYC = `RAV_STROBE_CYC;
  localparam int UPD_CYC = `RAV_DATA_CHG_CYC;

  logic [2:0] ctrl_r;
  rav_res_type res_act_r;
  rav_angle_type count_r;
  rav_angle_type count_nxt;
  rav_angle_type held_q;
  rav_angle_type out_mask;
  rav_angle_type out_word;
  rav_angle_type step_size;
  rav_angle_type masked_count;
  logic [7:0] ld_hi_r;
  logic [7:0] ld_lo_r;
  logic seq_strobe;
  logic seq_dir;
  logic upd_pulse;
  logic fall_pulse;
  logic frozen;
  logic mode_ct;
  logic high_byte_load_n;
  logic low_byte_load_n;
  logic ct_transfer_hold_n;
  logic wb_req;
  logic wb_wr_ack;
  logic wb_rd_req;
  logic [31:0] rd_word;

  assign mode_ct = !angle_compare_mode_n;
  // enables and hold pin take on load roles in compare mode
  assign high_byte_load_n = upper_byte_out_en_n;
  assign low_byte_load_n = lower_byte_out_en_n;
  assign ct_transfer_hold_n = freeze_n;

  // strobe and direction timing
  // two or more steps during one running sequence merge into one pending step; the loop stays below that rate
  rav_strobe_seq #(
    .LEAD_CYC(LEAD_CYC),
    .HIGH_CYC(HIGH_CYC),
    .UPD_CYC(UPD_CYC)
  ) u_seq (
    .clk(clk),
    .rst(rst),
    .step_req(vco_step),
    .step_up(vco_up),
    .strobe(seq_strobe),
    .dir(seq_dir),
    .upd_pulse(upd_pulse),
    .fall_pulse(fall_pulse)
  );

  // output hold latch
  // the latch runs on the internal strobe, one clock ahead of the pin
  rav_hold_latch u_latch (
    .clk(clk),
    .rst(rst),
    .strobe(seq_strobe),
    .freeze_n(freeze_n),
    .d(count_r),
    .q(held_q),
    .frozen(frozen)
  );

  always_comb begin
    case (res_act_r)
      2'b00: begin
        out_mask = `RAV_MASK_10;
        step_size = `RAV_STEP_10;
      end
      2'b01: begin
        out_mask = `RAV_MASK_12;
        step_size = `RAV_STEP_12;
      end
      2'b10: begin
        out_mask = `RAV_MASK_14;
        step_size = `RAV_STEP_14;
      end
      default: begin
        out_mask = `RAV_MASK_16;
        step_size = `RAV_STEP_16;
      end
    endcase
  end

  // one lsb per strobe, wrapping modulo full count
  // low bits are kept when resolution drops, so a return to 16 bits resumes exactly
  always_comb begin
    if (seq_dir) begin
      count_nxt = count_r + step_size;
    end else begin
      count_nxt = count_r - step_size;
    end
  end

  // counter runs regardless of the hold request
  // update lands a few cycles after strobe rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= 16'h0000;
    end else if (upd_pulse) begin
      count_r <= count_nxt;
    end
  end

  // resolution taken on strobe trailing edge
  // a new resolution never lands inside an update, so one step never mixes sizes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_act_r <= 2'(`RAV_CTRL_RESET);
    end else if (fall_pulse) begin
      res_act_r <= ctrl_r[`RAV_CTRL_RES_LSB +: 2];
    end
  end

  // live counter at the active resolution, as the host would see it
  assign masked_count = count_r & out_mask;

  // ripple-carry style wrap flag
  // follows the live counter, not the held word, so a turn counter sees every carry
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrap_flag_n <= 1'b1;
    end else if (seq_dir) begin
      wrap_flag_n <= !(masked_count == out_mask);
    end else begin
      wrap_flag_n <= !(masked_count == 16'h0000);
    end
  end

  // strobe pin, one flop behind the internal strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      update_strobe <= 1'b0;
    end else begin
      update_strobe <= seq_strobe;
    end
  end

  // direction pin, same delay as the strobe pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      direction <= 1'b1;
    end else begin
      direction <= seq_dir;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      track_ok <= 1'b1;
    end else begin
      track_ok <= !((loop_err_lsb > `RAV_ERR_LIMIT) || over_velocity || loop_fault);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      signal_missing <= 1'b0;
    end else begin
      signal_missing <= sin_lost && cos_lost;
    end
  end

  // bandwidth choice follows control at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_speed_sel <= 1'b0;
    end else begin
      loop_speed_sel <= ctrl_r[`RAV_CTRL_SPEED_BIT];
    end
  end

  // unused low bits forced to zero
  assign out_word = held_q & out_mask;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      angle_out <= 16'h0000;
    end else begin
      angle_out <= out_word;
    end
  end

  // drivers release one cycle after enables rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      angle_oe <= 2'b00;
    end else begin
      angle_oe[1] <= !mode_ct && !upper_byte_out_en_n;
      angle_oe[0] <= !mode_ct && !lower_byte_out_en_n;
    end
  end

  // byte load latches open while control is 1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ld_hi_r <= 8'h00;
    end else if (mode_ct && high_byte_load_n) begin
      ld_hi_r <= angle_in[15:8];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ld_lo_r <= 8'h00;
    end else if (mode_ct && low_byte_load_n) begin
      ld_lo_r <= angle_in[7:0];
    end
  end

  // transfer latch of the double buffer
  // the transfer latch takes the loaders one clock after they settle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ct_angle <= 16'h0000;
    end else if (mode_ct && ct_transfer_hold_n) begin
      ct_angle <= {ld_hi_r, ld_lo_r};
    end
  end

  // wishbone slave, one wait state, ack dropped after one cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land on the edge at which the master sees ack, while its request still stands
  assign wb_wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wb_rd_req = wb_req && !wb_we_i;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // resolution select held in control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `RAV_CTRL_RESET;
    end else if (wb_wr_ack && wb_sel_i[0] && wb_adr_i == `RAV_CTRL_OFS) begin
      ctrl_r <= wb_dat_i[2:0];
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      `RAV_CTRL_OFS: rd_word[2:0] = ctrl_r;
      `RAV_STATUS_OFS: begin
        rd_word[`RAV_ST_TRACK_BIT] = track_ok;
        rd_word[`RAV_ST_MISSING_BIT] = signal_missing;
        rd_word[`RAV_ST_DIR_BIT] = direction;
        rd_word[`RAV_ST_WRAP_BIT] = wrap_flag_n;
        rd_word[`RAV_ST_FROZEN_BIT] = frozen;
        rd_word[`RAV_ST_CT_BIT] = mode_ct;
        rd_word[`RAV_ST_RES_LSB +: 2] = res_act_r;
      end
      `RAV_LIVE_OFS: rd_word[15:0] = masked_count;
      `RAV_HELD_OFS: rd_word[15:0] = out_word;
      `RAV_CT_OFS: rd_word[15:0] = ct_angle;
      // unmapped offsets read zero
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_rd_req) begin
      wb_dat_o <= rd_word;
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end
endmodule // rav_angle_if
`default_nettype wire

// File: rav_angle_if_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rav_angle_if_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic update_strobe,
  input wire logic direction,
  input wire logic freeze_n,
  input wire logic upper_byte_out_en_n,
  input wire logic lower_byte_out_en_n,
  input wire logic angle_compare_mode_n,
  input wire logic [15:0] angle_out,
  input wire logic [1:0] angle_oe,
  input wire logic [7:0] loop_err_lsb,
  input wire logic over_velocity,
  input wire logic loop_fault,
  input wire logic sin_lost,
  input wire logic cos_lost,
  input wire logic track_ok,
  input wire logic signal_missing,
  input wire logic [15:0] ct_angle
);
  logic [2:0] quiet_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // counts cycles of hold with no strobe in the way
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_r <= 3'h0;
    end else if (!freeze_n && !update_strobe && angle_compare_mode_n) begin
      quiet_r <= (quiet_r == 3'h7) ? quiet_r : quiet_r + 3'h1;
    end else begin
      quiet_r <= 3'h0;
    end
  end
  strobe_width_a: assert property (
    $rose(update_strobe) |-> update_strobe[*8] ##1 update_strobe ##1 update_strobe ##1 !update_strobe)
    else $error("update strobe width wrong");
  dir_window_a: assert property (
    $rose(update_strobe) |-> direction == $past(direction, 13) ##1 $stable(direction))
    else $error("direction not steady around strobe");
  hold_steady_a: assert property (
    quiet_r >= 3'h5 |-> $stable(angle_out))
    else $error("angle moved while held");
  track_drop_a: assert property (
    (loop_err_lsb > 8'd65 || over_velocity || loop_fault)[*3] |-> !track_ok)
    else $error("tracking flag stayed high");
  loss_flag_a: assert property (
    ((sin_lost && cos_lost)[*3] |-> signal_missing) and ((!sin_lost || !cos_lost)[*3] |-> !signal_missing))
    else $error("loss flag wrong");
  byte_drive_a: assert property (
    angle_compare_mode_n && $past(angle_compare_mode_n)
      |-> angle_oe == ~{$past(upper_byte_out_en_n), $past(lower_byte_out_en_n)})
    else $error("byte drivers do not follow enables");
  compare_quiet_a: assert property (
    !angle_compare_mode_n && !$past(angle_compare_mode_n) |-> angle_oe == 2'h0)
    else $error("drivers on in compare mode");
  ct_hold_a: assert property (
    (!angle_compare_mode_n && !freeze_n)[*3] |-> $stable(ct_angle))
    else $error("transfer latch moved while closed");
endmodule // rav_angle_if_properties
`default_nettype wire

// File: rav_hold_latch.sv
`timescale 1ns/1ps
`default_nettype none
module rav_hold_latch (
  input wire logic clk,
  input wire logic rst,
  input wire logic strobe,
  input wire logic freeze_n,
  input wire logic [15:0] d,
  output logic [15:0] q,
  output logic frozen
);
  // a hold request is only taken while no strobe runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frozen <= 1'b0;
    end else if (!strobe) begin
      frozen <= !freeze_n;
    end
  end

  // transparent only with strobe low and no hold taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= 16'h0000;
    end else if (!strobe && !frozen) begin
      q <= d;
    end
  end
endmodule // rav_hold_latch
`default_nettype wire

// File: rav_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rav_host_model (
  input wire logic clk,
  input wire logic [15:0] angle_out,
  input wire logic [1:0] angle_oe,
  output logic freeze_n,
  output logic upper_byte_out_en_n,
  output logic lower_byte_out_en_n
);
  initial begin
    freeze_n = 1'b1;
    upper_byte_out_en_n = 1'b1;
    lower_byte_out_en_n = 1'b1;
  end
  // an undriven lane shows the inverse of the held byte, so a late enable is caught
  function automatic logic [7:0] bus_byte(input logic en, input logic [7:0] b);
    return en ? b : ~b;
  endfunction
  task automatic drive(input logic f, input logic u, input logic l);
    @(posedge clk);
    freeze_n <= f;
    upper_byte_out_en_n <= u;
    lower_byte_out_en_n <= l;
  endtask
  task automatic read_angle(input logic wide, output logic [15:0] v);
    drive(1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    // upper byte first, or both at once
    drive(1'b0, 1'b0, !wide);
    repeat (2) @(posedge clk);
    v = {bus_byte(angle_oe[1], angle_out[15:8]), bus_byte(angle_oe[0], angle_out[7:0])};
    if (!wide) begin
      drive(1'b0, 1'b1, 1'b0);
      repeat (2) @(posedge clk);
      v[7:0] = bus_byte(angle_oe[0], angle_out[7:0]);
    end
    drive(1'b1, 1'b1, 1'b1);
  endtask
endmodule // rav_host_model
`default_nettype wire

// File: rav_pkg.sv
package rav_pkg;
  typedef enum logic [1:0] {RAV_IDLE, RAV_LEAD, RAV_HIGH} rav_seq_type;
  typedef logic [1:0] rav_res_type;
  typedef logic [15:0] rav_angle_type;
endpackage

// File: rav_regs.svh
`ifndef RAV_REGS_SVH
`define RAV_REGS_SVH

// clock period
`define RAV_CLK_NS 40

// timing figures in ns and derived cycle counts
`define RAV_STROBE_MIN_NS 400
`define RAV_STROBE_MAX_NS 700
`define RAV_STROBE_CYC ((`RAV_STROBE_MIN_NS + `RAV_CLK_NS - 1) / `RAV_CLK_NS)
`define RAV_DATA_CHG_NS 50
`define RAV_DATA_CHG_CYC ((`RAV_DATA_CHG_NS + `RAV_CLK_NS - 1) / `RAV_CLK_NS)
`define RAV_DATA_VALID_NS 200
`define RAV_DATA_VALID_CYC (`RAV_DATA_VALID_NS / `RAV_CLK_NS)
`define RAV_DIR_SETUP_NS 500
`define RAV_DIR_SETUP_CYC ((`RAV_DIR_SETUP_NS + `RAV_CLK_NS - 1) / `RAV_CLK_NS)
`define RAV_DIR_HOLD_NS 20
`define RAV_DIR_HOLD_CYC ((`RAV_DIR_HOLD_NS + `RAV_CLK_NS - 1) / `RAV_CLK_NS)

// loop error limit in lsb of the selected resolution
`define RAV_ERR_LIMIT 8'd65

// register byte offsets
`define RAV_CTRL_OFS 8'h00
`define RAV_STATUS_OFS 8'h04
`define RAV_LIVE_OFS 8'h08
`define RAV_HELD_OFS 8'h0c
`define RAV_CT_OFS 8'h10

// control fields
`define RAV_CTRL_RES_LSB 0
`define RAV_CTRL_SPEED_BIT 2
`define RAV_CTRL_RESET 3'h3

// status fields
`define RAV_ST_TRACK_BIT 0
`define RAV_ST_MISSING_BIT 1
`define RAV_ST_DIR_BIT 2
`define RAV_ST_WRAP_BIT 3
`define RAV_ST_FROZEN_BIT 4
`define RAV_ST_CT_BIT 5
`define RAV_ST_RES_LSB 6

// resolution codes: masks and one-lsb steps
`define RAV_MASK_10 16'hffc0
`define RAV_MASK_12 16'hfff0
`define RAV_MASK_14 16'hfffc
`define RAV_MASK_16 16'hffff
`define RAV_STEP_10 16'h0040
`define RAV_STEP_12 16'h0010
`define RAV_STEP_14 16'h0004
`define RAV_STEP_16 16'h0001

`endif

// File: rav_strobe_seq.sv
`timescale 1ns/1ps
`default_nettype none
module rav_strobe_seq #(
  parameter int LEAD_CYC = 13,
  parameter int HIGH_CYC = 10,
  parameter int UPD_CYC = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic step_req,
  input wire logic step_up,
  output logic strobe,
  output logic dir,
  output logic upd_pulse,
  output logic fall_pulse
);
  import rav_pkg::*;

  rav_seq_type state_r;
  logic [4:0] cnt_r;
  logic pend_r;
  logic pend_up_r;

  // one pending step is kept while a strobe sequence runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
      pend_up_r <= 1'b1;
    end else if (step_req) begin
      pend_r <= 1'b1;
      pend_up_r <= step_up;
    end else if (state_r == RAV_IDLE) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= RAV_IDLE;
      cnt_r <= 5'h00;
      strobe <= 1'b0;
      dir <= 1'b1;
      upd_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end else begin
      upd_pulse <= 1'b0;
      fall_pulse <= 1'b0;
      case (state_r)
        RAV_IDLE: begin
          if (pend_r) begin
            dir <= pend_up_r;
            cnt_r <= 5'h00;
            state_r <= RAV_LEAD;
          end
        end
        RAV_LEAD: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == 5'(LEAD_CYC - 1)) begin
            strobe <= 1'b1;
            cnt_r <= 5'h00;
            state_r <= RAV_HIGH;
          end
        end
        RAV_HIGH: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == 5'(UPD_CYC - 1)) begin
            upd_pulse <= 1'b1;
          end
          if (cnt_r == 5'(HIGH_CYC - 1)) begin
            strobe <= 1'b0;
            fall_pulse <= 1'b1;
            state_r <= RAV_IDLE;
          end
        end
        default: state_r <= RAV_IDLE;
      endcase
    end
  end
endmodule // rav_strobe_seq
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, vco_step, vco_up, over_velocity, loop_fault;
  logic sin_lost, cos_lost, freeze_n, upper_byte_out_en_n, lower_byte_out_en_n, angle_compare_mode_n;
  logic update_strobe, direction, wrap_flag_n, track_ok, signal_missing, loop_speed_sel;
  logic [7:0] wb_adr_i, loop_err_lsb;
  logic [3:0] wb_sel_i, sel_v;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] angle_in, angle_out, ec, v;
  logic [1:0] angle_oe, act, ctl;
  rav_pkg::rav_angle_type ct_angle;
  int bad_count = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  rav_angle_if uut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .vco_step, .vco_up, .loop_err_lsb, .over_velocity, .loop_fault, .sin_lost, .cos_lost, .freeze_n,
    .upper_byte_out_en_n, .lower_byte_out_en_n, .angle_compare_mode_n, .angle_in, .angle_out, .angle_oe,
    .update_strobe, .direction, .wrap_flag_n, .track_ok, .signal_missing, .loop_speed_sel, .ct_angle);
  rav_host_model host (.clk, .angle_out, .angle_oe, .freeze_n, .upper_byte_out_en_n, .lower_byte_out_en_n);
  function automatic logic [15:0] msk(input logic [1:0] a);
    return 16'hffff << (6 - 2 * a);
  endfunction
  function automatic logic [15:0] stp(input logic [1:0] a);
    return 16'h1 << (6 - 2 * a);
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic time_out();
    bad_count++;
    $display("[ERR] %0t wait ran out", $time);
    give_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, want);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel_v;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) time_out();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic step(input logic up, input logic mid);
    int n;
    logic [15:0] m;
    @(posedge clk);
    vco_step <= 1'b1;
    vco_up <= up;
    @(posedge clk);
    vco_step <= 1'b0;
    n = 0;
    while (update_strobe !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) time_out();
    if (mid) host.drive(1'b0, 1'b1, 1'b1);
    while (update_strobe !== 1'b0 && n < 80) begin
      @(posedge clk);
      n++;
    end
    if (n >= 80) time_out();
    ec = up ? ec + stp(act) : ec - stp(act);
    act = ctl;
    repeat (3) @(posedge clk);
    m = ec & msk(act);
    chk(direction, up);
    chk(wrap_flag_n, !(up ? m == msk(act) : m == 16'h0));
  endtask
  initial begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, vco_step, vco_up, over_velocity, loop_fault, sin_lost, cos_lost} = '0;
    {wb_adr_i, loop_err_lsb, wb_dat_i, angle_in} = '0;
    wb_sel_i = 4'hf;
    sel_v = 4'hf;
    angle_compare_mode_n = 1'b1;
    ec = 16'h0;
    act = 2'h3;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    for (int r = 0; r < 4; r++) begin
      ctl = r[1:0];
      wb(1'b1, 8'h00, r);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd[7:6], act);
      step(1'b1, 1'b0);
      step(1'b1, 1'b0);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd[7:6], ctl);
      wb(1'b0, 8'h08, 32'h0);
      chk(rd, ec & msk(act));
      host.read_angle(r[0], v);
      chk(v, ec & msk(act));
    end
    ctl = 2'h0;
    wb(1'b1, 8'h00, 32'h0);
    repeat (3) step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    repeat (5) @(posedge clk);
    v = ec & msk(act);
    chk(angle_out, v);
    step(1'b1, 1'b0);
    chk(angle_out, v);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, ec & msk(act));
    host.drive(1'b1, 1'b1, 1'b1);
    repeat (5) @(posedge clk);
    chk(angle_out, ec & msk(act));
    // tracking flag is only observed, never used to lower the resolution
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      loop_err_lsb <= (i == 0) ? 8'd66 : 8'd65;
      over_velocity <= (i == 1);
      loop_fault <= (i == 2);
      sin_lost <= (i < 2);
      cos_lost <= (i == 0 || i == 2);
      repeat (4) @(posedge clk);
      chk(track_ok, i == 3);
      chk(signal_missing, i == 0);
    end
    wb(1'b1, 8'h00, 32'h4);
    repeat (2) @(posedge clk);
    chk(loop_speed_sel, 1'b1);
    wb(1'b1, 8'h00, 32'h0);
    repeat (2) @(posedge clk);
    chk(loop_speed_sel, 1'b0);
    sel_v = 4'he;
    wb(1'b1, 8'h00, 32'h7);
    sel_v = 4'hf;
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    @(posedge clk);
    angle_compare_mode_n <= 1'b0;
    angle_in <= 16'h1234;
    repeat (4) @(posedge clk);
    chk(ct_angle, 16'h1234);
    host.drive(1'b1, 1'b0, 1'b0);
    @(posedge clk);
    angle_in <= 16'habcd;
    repeat (4) @(posedge clk);
    chk(ct_angle, 16'h1234);
    host.drive(1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge clk);
    chk(ct_angle, 16'h1234);
    host.drive(1'b1, 1'b1, 1'b1);
    repeat (4) @(posedge clk);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'habcd);
    give_verdict();
  end
endmodule // tb_top
bind rav_angle_if rav_angle_if_properties chk_i (.clk, .rst, .update_strobe, .direction, .freeze_n,
  .upper_byte_out_en_n, .lower_byte_out_en_n, .angle_compare_mode_n, .angle_out, .angle_oe, .loop_err_lsb,
  .over_velocity, .loop_fault, .sin_lost, .cos_lost, .track_ok, .signal_missing, .ct_angle);
`default_nettype wire
